// >>> include/adcsq_pkg.sv
// package: register map, field positions, codes and timing for the converter sequencer
package adcsq_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] ADCSQ_OFF_CTRL_A  = 3'h0; // converter_control_a
	localparam logic [2:0] ADCSQ_OFF_CTRL_B  = 3'h1; // converter_control_b
	localparam logic [2:0] ADCSQ_OFF_TRIG    = 3'h2; // converter_trigger_select
	localparam logic [2:0] ADCSQ_OFF_RES_HI  = 3'h3; // result high
	localparam logic [2:0] ADCSQ_OFF_RES_LO  = 3'h4; // result low
	localparam logic [2:0] ADCSQ_OFF_STATUS  = 3'h5; // done flag and busy state
	// field positions
	localparam int ADCSQ_POS_ENABLE = 0;  // converter_enable in control a
	localparam int ADCSQ_POS_GO     = 1;  // conversion status in control a
	localparam int ADCSQ_POS_CHAN   = 2;  // channel_select lsb in control a
	localparam int ADCSQ_POS_FMT    = 7;  // result_format_select in control b
	localparam int ADCSQ_POS_CLKSEL = 4;  // conversion_clock_select lsb in control b
	localparam int ADCSQ_POS_PREF   = 0;  // positive_reference_select lsb in control b
	localparam int ADCSQ_POS_TRIG   = 4;  // auto_start_source_select lsb in trigger reg
	// reset values
	localparam logic [7:0] ADCSQ_RST_CTRL = 8'h00; // all control registers
	// bit periods per conversion: 11.5, counted in half periods
	localparam int ADCSQ_CONV_HALF_PERIODS = 23;
	localparam int ADCSQ_RESULT_BITS       = 10;
	// system clock and rc period
	localparam int ADCSQ_CLK_MHZ     = 20;
	localparam int ADCSQ_RC_PERIOD_NS = 2000; // chosen within 1 to 6 us
	localparam int ADCSQ_CLK_NS      = 1000 / ADCSQ_CLK_MHZ;
	localparam int ADCSQ_RC_CYCLES   = ADCSQ_RC_PERIOD_NS / ADCSQ_CLK_NS;
	// channel codes
	localparam logic [4:0] ADCSQ_CH_LAST_PIN = 5'h0B; // analog input 11
	localparam logic [4:0] ADCSQ_CH_TEMP     = 5'h1D; // temperature indicator
	localparam logic [4:0] ADCSQ_CH_FIXREF   = 5'h1F; // fixed_reference_buffer
	// reference codes
	localparam logic [1:0] ADCSQ_REF_SUPPLY = 2'h0;
	localparam logic [1:0] ADCSQ_REF_PIN    = 2'h2;
	// trigger codes
	localparam logic [3:0] ADCSQ_TRG_NONE = 4'h0;
	localparam logic [3:0] ADCSQ_TRG_TMR0 = 4'h3;
	localparam logic [3:0] ADCSQ_TRG_TMR1 = 4'h4;
	localparam logic [3:0] ADCSQ_TRG_TMR2 = 4'h5;
	localparam logic [3:0] ADCSQ_TRG_LC1  = 4'h8;
	localparam logic [3:0] ADCSQ_TRG_LC2  = 4'h9;
	// analog front end selection carried as one group
	typedef struct packed {
		logic       channel_valid;  // a real channel is connected
		logic [4:0] channel_code;   // channel_select value
		logic       reference_pin;  // positive_reference_node on external pin
		logic       reference_ok;   // reference code not reserved
		logic       powered;        // converter_enable
	} adcsq_front_t;
	// sequencer states
	typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_RUN} adcsq_state_t;
endpackage

// >>> hdl/adcsq_clkdiv.sv
// conversion clock tick generator: half-period ticks of the selected source
module adcsq_clkdiv
	import adcsq_pkg::*;
#(
	parameter int RC_CYCLES = ADCSQ_RC_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [2:0] clock_select,
	output logic            half_tick
);
	// refuse rc periods that the 7-bit half-period counter cannot hold
	if (RC_CYCLES < 2 || RC_CYCLES > 255) begin : g_bad_rc
		$error("rc period out of range");
	end
	logic [6:0] count;      // cycles in current half period
	logic [6:0] next_count; // next count
	logic [6:0] half_len;   // cycles per half bit period
	// half period length per code
	always_comb begin
		case (clock_select)
			3'h0: half_len = 7'h01;
			3'h4: half_len = 7'h02;
			3'h1: half_len = 7'h04;
			3'h5: half_len = 7'h08;
			3'h2: half_len = 7'h10;
			3'h6: half_len = 7'h20;
			default: half_len = 7'(RC_CYCLES / 2); // internal_rc_clock, both codes
		endcase
		half_tick = run && (count == half_len - 7'h01);
		if (!run || half_tick) begin
			next_count = 7'h00;
		end else begin
			next_count = count + 7'h01;
		end
	end
	// count register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 7'h00;
		end else begin
			count <= next_count;
		end
	end
endmodule

// >>> hdl/adcsq_top.sv
// converter sequencer control: registers, start/busy, triggers and result placement
// Function
// - five bit channel code selects input
// - writing status one starts, reads busy
// - hardware clears status on completion
// - enable bit set to one powers converter
// - right format zeroes high six bits
// - left format zeroes low six bits
// - three bit code picks conversion clock
// - reference code selects supply or pin
// - four bit code picks auto start source
// - sources act on rising edge only
// - timer overflow still sets own flag
// - left format places bits nine down
// - right format places bits nine eight
// - unimplemented control bits read zero
// - completion clears status, flags, loads result
// - abort loads partial, fill last bit
// - conversion lasts eleven and half periods
// - source edge sets status like software
//
// Local design decisions: the register addresses and the strobed register port.
module adcsq_top
	import adcsq_pkg::*;
#(
	parameter int RC_CYCLES = ADCSQ_RC_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       timer_zero_wrap_event,
	input  wire logic       timer_one_wrap_event,
	input  wire logic       timer_two_period_event,
	input  wire logic       logic_cell_one_output,
	input  wire logic       logic_cell_two_output,
	input  wire logic       comparator_out,
	output logic            sample_hold,
	output adcsq_front_t    front,
	output logic            conversion_done_flag
);
	// control fields
	logic       enable;         // converter_enable
	logic       busy;           // conversion status bit
	logic [4:0] chan;           // channel_select
	logic       fmt_right;      // result_format_select
	logic [2:0] clk_sel;        // conversion_clock_select
	logic [1:0] pref;           // positive_reference_select
	logic [3:0] trig_sel;       // auto_start_source_select
	logic [7:0] res_hi;         // result high register
	logic [7:0] res_lo;         // result low register
	logic       done_flag;      // completion flag, software clears
	logic [7:0] rdata;          // read data register
	// next values
	logic       next_enable;
	logic       next_busy;
	logic [4:0] next_chan;
	logic       next_fmt_right;
	logic [2:0] next_clk_sel;
	logic [1:0] next_pref;
	logic [3:0] next_trig_sel;
	logic [7:0] next_res_hi;
	logic [7:0] next_res_lo;
	logic       next_done_flag;
	logic [7:0] next_rdata;
	// sequencer state
	adcsq_state_t state;        // idle or converting
	adcsq_state_t next_state;
	logic [4:0]   half_cnt;     // half bit periods elapsed
	logic [4:0]   next_half_cnt;
	logic [9:0]   sar;          // successive approximation register
	logic [9:0]   next_sar;
	logic [3:0]   bit_idx;      // bits decided so far
	logic [3:0]   next_bit_idx;
	// trigger synchronisers and edge detect
	logic [4:0] trig_s1;        // first stage, read only by second
	logic [4:0] trig_s2;        // second stage
	logic [4:0] trig_s3;        // previous value for edge detect
	logic [1:0] cmp_sync;       // comparator synchroniser
	logic       trig_level;     // selected source level
	logic       trig_prev;      // selected source, one cycle earlier
	logic       trig_edge;      // rising edge of selected source
	logic       half_tick;      // half bit period tick
	logic       wr_go;          // software start
	logic       wr_stop;        // software abort
	logic       finish;         // normal completion
	logic       abort;          // early end
	logic [9:0] result;         // value to load
	logic [9:0] filled;         // partial value with fill

	// conversion clock ticks
	adcsq_clkdiv #(
		.RC_CYCLES (RC_CYCLES)
	) u_clkdiv (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.run          (state == ADCSQ_RUN),
		.clock_select (clk_sel),
		.half_tick    (half_tick)
	);

	// two flop synchronisers for pin-side inputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1  <= 5'h00;
			trig_s2  <= 5'h00;
			trig_s3  <= 5'h00;
			cmp_sync <= 2'h0;
		end else begin
			trig_s1  <= {logic_cell_two_output, logic_cell_one_output,
				timer_two_period_event, timer_one_wrap_event, timer_zero_wrap_event};
			trig_s2  <= trig_s1;
			trig_s3  <= trig_s2;
			cmp_sync <= {cmp_sync[0], comparator_out};
		end
	end

	// source selection and rising edge; wrap events only observed, their own flags untouched
	always_comb begin
		case (trig_sel)
			ADCSQ_TRG_TMR0: begin trig_level = trig_s2[0]; trig_prev = trig_s3[0]; end
			ADCSQ_TRG_TMR1: begin trig_level = trig_s2[1]; trig_prev = trig_s3[1]; end
			ADCSQ_TRG_TMR2: begin trig_level = trig_s2[2]; trig_prev = trig_s3[2]; end
			ADCSQ_TRG_LC1:  begin trig_level = trig_s2[3]; trig_prev = trig_s3[3]; end
			ADCSQ_TRG_LC2:  begin trig_level = trig_s2[4]; trig_prev = trig_s3[4]; end
			default:        begin trig_level = 1'b0; trig_prev = 1'b0; end // none or reserved
		endcase
		trig_edge = trig_level && !trig_prev; // a held level starts nothing more
	end

	// analog front end selection
	always_comb begin
		front.channel_code  = chan;
		front.channel_valid = (chan <= ADCSQ_CH_LAST_PIN) || (chan == ADCSQ_CH_TEMP)
			|| (chan == ADCSQ_CH_FIXREF); // other codes connect nothing
		front.reference_pin = (pref == ADCSQ_REF_PIN);
		front.reference_ok  = (pref == ADCSQ_REF_SUPPLY) || (pref == ADCSQ_REF_PIN);
		front.powered       = enable;
	end

	// start, abort and result formatting
	always_comb begin
		wr_go   = reg_write && (reg_addr == ADCSQ_OFF_CTRL_A) && reg_wdata[ADCSQ_POS_GO];
		wr_stop = reg_write && (reg_addr == ADCSQ_OFF_CTRL_A) && !reg_wdata[ADCSQ_POS_GO];
		finish  = (state == ADCSQ_RUN) && half_tick
			&& (half_cnt == 5'(ADCSQ_CONV_HALF_PERIODS - 1));
		abort   = (state == ADCSQ_RUN) && !finish && (wr_stop || !enable);
		// unconverted bits copy the last decided bit
		filled = sar;
		for (int i = 0; i < ADCSQ_RESULT_BITS; i++) begin
			if (i < ADCSQ_RESULT_BITS - int'(bit_idx)) begin
				filled[i] = (bit_idx == 4'h0) ? 1'b0 : sar[ADCSQ_RESULT_BITS - int'(bit_idx)];
			end
		end
		result = finish ? sar : filled;
	end

	// sequencer: bit decisions every two half periods after sampling
	always_comb begin
		next_state    = state;
		next_half_cnt = half_cnt;
		next_sar      = sar;
		next_bit_idx  = bit_idx;
		case (state)
			ADCSQ_IDLE: begin
				if (enable && (wr_go || trig_edge)) begin
					next_state    = ADCSQ_RUN;
					next_half_cnt = 5'h00;
					next_sar      = 10'h000;
					next_bit_idx  = 4'h0;
				end
			end
			ADCSQ_RUN: begin
				if (finish || abort) begin
					next_state = ADCSQ_IDLE;
				end else if (half_tick) begin
					next_half_cnt = half_cnt + 5'h01;
					// decide one bit at the end of each full period from the second
					if (half_cnt[0] && half_cnt >= 5'h03 && bit_idx < 4'(ADCSQ_RESULT_BITS)) begin
						next_sar[4'(9) - bit_idx] = cmp_sync[1];
						next_bit_idx = bit_idx + 4'h1;
					end
				end
			end
			default: next_state = ADCSQ_IDLE;
		endcase
	end

	// register file next values
	always_comb begin
		next_enable    = enable;
		next_chan      = chan;
		next_fmt_right = fmt_right;
		next_clk_sel   = clk_sel;
		next_pref      = pref;
		next_trig_sel  = trig_sel;
		next_res_hi    = res_hi;
		next_res_lo    = res_lo;
		next_done_flag = done_flag;
		next_busy      = busy;
		if (reg_write) begin
			case (reg_addr)
				ADCSQ_OFF_CTRL_A: begin
					next_enable = reg_wdata[ADCSQ_POS_ENABLE];
					next_chan   = reg_wdata[ADCSQ_POS_CHAN +: 5];
				end
				ADCSQ_OFF_CTRL_B: begin
					next_fmt_right = reg_wdata[ADCSQ_POS_FMT];
					next_clk_sel   = reg_wdata[ADCSQ_POS_CLKSEL +: 3];
					next_pref      = reg_wdata[ADCSQ_POS_PREF +: 2];
				end
				ADCSQ_OFF_TRIG:   next_trig_sel = reg_wdata[ADCSQ_POS_TRIG +: 4];
				ADCSQ_OFF_RES_HI: next_res_hi   = reg_wdata;
				ADCSQ_OFF_RES_LO: next_res_lo   = reg_wdata;
				ADCSQ_OFF_STATUS: if (reg_wdata[0]) next_done_flag = 1'b0; // write one clears
				default: ;
			endcase
		end
		// busy follows the sequencer, set on start, cleared on end
		next_busy = (next_state == ADCSQ_RUN);
		if (finish || abort) begin
			if (finish) begin
				next_done_flag = 1'b1; // set wins over a clear
			end
			if (fmt_right) begin
				next_res_hi = {6'h00, result[9:8]};
				next_res_lo = result[7:0];
			end else begin
				next_res_hi = result[9:2];
				next_res_lo = {result[1:0], 6'h00};
			end
		end
		// read mux, unimplemented bits zero
		case (reg_addr)
			ADCSQ_OFF_CTRL_A: next_rdata = {1'b0, chan, busy, enable};
			ADCSQ_OFF_CTRL_B: next_rdata = {fmt_right, clk_sel, 2'h0, pref};
			ADCSQ_OFF_TRIG:   next_rdata = {trig_sel, 4'h0};
			ADCSQ_OFF_RES_HI: next_rdata = res_hi;
			ADCSQ_OFF_RES_LO: next_rdata = res_lo;
			ADCSQ_OFF_STATUS: next_rdata = {6'h00, busy, done_flag};
			default:          next_rdata = 8'h00;
		endcase
		if (!reg_read) begin
			next_rdata = 8'h00;
		end
	end

	// state registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ADCSQ_IDLE;
			half_cnt  <= 5'h00;
			sar       <= 10'h000;
			bit_idx   <= 4'h0;
			enable    <= ADCSQ_RST_CTRL[ADCSQ_POS_ENABLE];
			busy      <= 1'b0;
			chan      <= 5'h00;
			fmt_right <= ADCSQ_RST_CTRL[ADCSQ_POS_FMT];
			clk_sel   <= 3'h0;
			pref      <= 2'h0;
			trig_sel  <= 4'h0;
			res_hi    <= 8'h00;
			res_lo    <= 8'h00;
			done_flag <= 1'b0;
			rdata     <= 8'h00;
		end else begin
			state     <= next_state;
			half_cnt  <= next_half_cnt;
			sar       <= next_sar;
			bit_idx   <= next_bit_idx;
			enable    <= next_enable;
			busy      <= next_busy;
			chan      <= next_chan;
			fmt_right <= next_fmt_right;
			clk_sel   <= next_clk_sel;
			pref      <= next_pref;
			trig_sel  <= next_trig_sel;
			res_hi    <= next_res_hi;
			res_lo    <= next_res_lo;
			done_flag <= next_done_flag;
			rdata     <= next_rdata;
		end
	end

	// outputs
	assign reg_rdata            = rdata;
	assign conversion_done_flag = done_flag;
	assign sample_hold          = busy;
endmodule

// >>> tb/adcsq_chk.sv
// checker: port-level properties of the converter sequencer
module adcsq_chk
	import adcsq_pkg::*;
#(
	parameter int RC_CYCLES = ADCSQ_RC_CYCLES
) (
	input wire logic         core_clk,
	input wire logic         rst_n,
	input wire logic [2:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic         reg_write,
	input wire logic         reg_read,
	input wire logic [7:0]   reg_rdata,
	input wire logic         sample_hold,
	input wire adcsq_front_t front,
	input wire logic         conversion_done_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// software start request on control a
	sequence s_go;
		reg_write && reg_addr == ADCSQ_OFF_CTRL_A && reg_wdata[ADCSQ_POS_GO];
	endsequence
	// normal completion raises the sticky flag
	sequence s_finish;
		$rose(conversion_done_flag);
	endsequence
	AST_START: assert property (s_go ##0 (front.powered && !sample_hold) |=> sample_hold)
		else $error("start write did not raise busy");
	AST_OFF_IDLE: assert property (!front.powered && !sample_hold |=> !sample_hold)
		else $error("conversion began while converter off");
	AST_OFF_ABORT: assert property (sample_hold && !front.powered |-> ##[0:1] !sample_hold)
		else $error("conversion kept running while off");
	AST_END: assert property (s_finish |-> $fell(sample_hold))
		else $error("done flag rose without busy falling");
	AST_LENGTH: assert property (s_finish |-> $past(sample_hold, 20))
		else $error("conversion finished too early");
	AST_CHAN: assert property (front.channel_valid == (
		front.channel_code <= ADCSQ_CH_LAST_PIN || front.channel_code == ADCSQ_CH_TEMP
		|| front.channel_code == ADCSQ_CH_FIXREF))
		else $error("channel validity wrong");
	// reference decode held against the code read back from control b
	AST_REF: assert property ($past(reg_read) && $past(reg_addr) == ADCSQ_OFF_CTRL_B
		|-> $past(front.reference_pin) == (reg_rdata[1:0] == ADCSQ_REF_PIN)
		&& $past(front.reference_ok) == (reg_rdata[1:0] != 2'h1 && reg_rdata[1:0] != 2'h3)
		&& reg_rdata[3:2] == 2'h0)
		else $error("reference decode wrong");
	AST_IDLE_RD: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	AST_STATUS: assert property ($past(reg_read) && $past(reg_addr) == ADCSQ_OFF_STATUS
		|-> reg_rdata == {6'h00, $past(sample_hold), $past(conversion_done_flag)})
		else $error("status read wrong");
	AST_CTRL_RD: assert property ($past(reg_read)
		&& $past(reg_addr) == ADCSQ_OFF_CTRL_A
		|-> !reg_rdata[7] && reg_rdata[ADCSQ_POS_GO] == $past(sample_hold))
		else $error("control a read wrong");
	AST_CLEAR: assert property (conversion_done_flag && !sample_hold && reg_write
		&& reg_addr == ADCSQ_OFF_STATUS && reg_wdata[0] |=> !conversion_done_flag)
		else $error("done flag not cleared");
endmodule
bind adcsq_top adcsq_chk #(.RC_CYCLES(RC_CYCLES)) u_adcsq_chk (
	.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.sample_hold(sample_hold), .front(front), .conversion_done_flag(conversion_done_flag)
);

// >>> tb/adcsq_top_bench.sv
// testbench: register, conversion, abort and trigger scenarios
module adcsq_top_bench
	import adcsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         RC = 8;        // shortened rc period
	localparam int         HALF[8] = '{1, 4, 16, RC / 2, 2, 8, 32, RC / 2};
	localparam logic [4:0] CH[5] = '{5'h0B, 5'h0C, 5'h1C, 5'h1D, 5'h1E};
	localparam logic [4:0] CHV = 5'b01001; // validity of CH entries
	localparam logic [3:0] TRG[5] = '{ADCSQ_TRG_TMR0, ADCSQ_TRG_TMR1, ADCSQ_TRG_TMR2,
		ADCSQ_TRG_LC1, ADCSQ_TRG_LC2};
	logic         core_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [2:0]   reg_addr = 3'h0;
	logic [7:0]   reg_wdata = 8'h00;
	logic         reg_write = 1'b0;
	logic         reg_read = 1'b0;
	logic         comparator_out = 1'b0;
	logic [4:0]   src = 5'h00;  // trigger sources in TRG order
	logic [7:0]   reg_rdata;
	logic         sample_hold;
	logic         conversion_done_flag;
	adcsq_front_t front;
	logic [7:0]   d;            // last read value
	int           n;            // busy cycles seen
	int           fails = 0;
	int           tests_run = 0;
	int           cycles = 0;
	adcsq_top #(.RC_CYCLES(RC)) u_adcsq_top (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.timer_zero_wrap_event(src[0]), .timer_one_wrap_event(src[1]),
		.timer_two_period_event(src[2]), .logic_cell_one_output(src[3]),
		.logic_cell_two_output(src[4]), .comparator_out(comparator_out),
		.sample_hold(sample_hold), .front(front), .conversion_done_flag(conversion_done_flag)
	);
	// 20 MHz clock
	always #25 core_clk = ~core_clk;
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// byte compare
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle write
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	// read, data taken in the following cycle, then compared
	task automatic chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
		cmp8(d, exp);
	endtask
	// count cycles until busy drops
	task automatic wait_idle();
		n = 0;
		@(negedge core_clk);
		while (sample_hold !== 1'b0 && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic t_regs();
		chk(ADCSQ_OFF_CTRL_A, 8'h00);
		chk(ADCSQ_OFF_CTRL_B, 8'h00);
		chk(ADCSQ_OFF_TRIG, 8'h00);
		wr(3'h7, 8'hFF);
		chk(3'h7, 8'h00);
		wr(ADCSQ_OFF_CTRL_A, 8'hFC);
		chk(ADCSQ_OFF_CTRL_A, 8'h7C);
		cmp8({2'h0, front.channel_valid, front.channel_code}, 8'h3F);
		wr(ADCSQ_OFF_CTRL_B, 8'hFE);
		chk(ADCSQ_OFF_CTRL_B, 8'hF2);
		cmp8({6'h0, front.reference_pin, front.reference_ok}, 8'h03);
		wr(ADCSQ_OFF_CTRL_B, 8'h01);
		@(negedge core_clk);
		cmp8({6'h0, front.reference_pin, front.reference_ok}, 8'h00);
		wr(ADCSQ_OFF_TRIG, 8'hFF);
		chk(ADCSQ_OFF_TRIG, 8'hF0);
		wr(ADCSQ_OFF_TRIG, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(ADCSQ_OFF_CTRL_A, {1'b0, CH[i], 2'b00});
			@(negedge core_clk);
			cmp8({7'h0, front.channel_valid}, {7'h0, CHV[i]});
		end
	endtask
	// one conversion over preset result registers
	task automatic t_conv(input logic f, input logic c, input logic [7:0] hi, lo);
		@(posedge core_clk);
		comparator_out <= c;
		wr(ADCSQ_OFF_RES_HI, 8'hFF);
		wr(ADCSQ_OFF_RES_LO, 8'hFF);
		wr(ADCSQ_OFF_CTRL_B, {f, 7'h00});
		wr(ADCSQ_OFF_CTRL_A, 8'h01);
		repeat (4) @(posedge core_clk);
		wr(ADCSQ_OFF_CTRL_A, 8'h03);
		chk(ADCSQ_OFF_CTRL_A, 8'h03);
		wait_idle();
		cmp8({6'h0, front.powered, conversion_done_flag}, 8'h03);
		chk(ADCSQ_OFF_STATUS, 8'h01);
		chk(ADCSQ_OFF_CTRL_A, 8'h01);
		chk(ADCSQ_OFF_RES_HI, hi);
		chk(ADCSQ_OFF_RES_LO, lo);
		wr(ADCSQ_OFF_STATUS, 8'h01);
		chk(ADCSQ_OFF_STATUS, 8'h00);
	endtask
	// conversion length for every clock code
	task automatic t_clk();
		for (int k = 0; k < 8; k++) begin
			wr(ADCSQ_OFF_CTRL_B, {1'b1, k[2:0], 4'h0});
			wr(ADCSQ_OFF_CTRL_A, 8'h03);
			wait_idle();
			cmp8({7'h0, n >= 23 * HALF[k] - 2 && n <= 24 * HALF[k] + 2}, 8'h01);
		end
		wr(ADCSQ_OFF_STATUS, 8'h01);
	endtask
	// stop by clearing the status bit, then by switching off
	task automatic t_abort();
		wr(ADCSQ_OFF_CTRL_B, 8'hD0);
		wr(ADCSQ_OFF_RES_HI, 8'h00);
		wr(ADCSQ_OFF_RES_LO, 8'h00);
		wr(ADCSQ_OFF_CTRL_A, 8'h03);
		repeat (60) @(posedge core_clk);
		wr(ADCSQ_OFF_CTRL_A, 8'h01);
		chk(ADCSQ_OFF_STATUS, 8'h00);
		chk(ADCSQ_OFF_RES_HI, 8'h03);
		chk(ADCSQ_OFF_RES_LO, 8'hFF);
		wr(ADCSQ_OFF_CTRL_A, 8'h03);
		repeat (20) @(posedge core_clk);
		wr(ADCSQ_OFF_CTRL_A, 8'h00);
		chk(ADCSQ_OFF_STATUS, 8'h00);
		cmp8({6'h0, front.powered, sample_hold}, 8'h00);
		wr(ADCSQ_OFF_CTRL_A, 8'h02);
		chk(ADCSQ_OFF_CTRL_A, 8'h00);
	endtask
	// each auto-start source: foreign edge, own edge, held level
	task automatic t_trig();
		wr(ADCSQ_OFF_CTRL_B, 8'h00);
		wr(ADCSQ_OFF_CTRL_A, 8'h01);
		for (int i = 0; i < 5; i++) begin
			wr(ADCSQ_OFF_TRIG, {TRG[i], 4'h0});
			@(posedge core_clk);
			src <= 5'(1 << ((i + 1) % 5));
			repeat (8) @(posedge core_clk);
			chk(ADCSQ_OFF_STATUS, 8'h00);
			@(posedge core_clk);
			src <= 5'(1 << i);
			repeat (8) @(posedge core_clk);
			wait_idle();
			chk(ADCSQ_OFF_STATUS, 8'h01);
			wr(ADCSQ_OFF_STATUS, 8'h01);
			repeat (40) @(posedge core_clk);
			chk(ADCSQ_OFF_STATUS, 8'h00);
			@(posedge core_clk);
			src <= 5'h00;
		end
		wr(ADCSQ_OFF_TRIG, 8'h10);
		@(posedge core_clk);
		src <= 5'h1F;
		repeat (8) @(posedge core_clk);
		chk(ADCSQ_OFF_STATUS, 8'h00);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_conv(1'b1, 1'b0, 8'h00, 8'h00);
		t_conv(1'b0, 1'b1, 8'hFF, 8'hC0);
		t_conv(1'b1, 1'b1, 8'h03, 8'hFF);
		t_clk();
		t_abort();
		t_trig();
		finish_test();
	end
endmodule
